// ===== common/acc_pkg.sv
// Constants, field positions and types of the analog comparator control block
package acc_pkg;
  // Number of comparator units and register address width
  localparam int ACC_UNITS = 3;
  localparam int ACC_AW = 8;
  localparam int ACC_SYNC_STAGES = 2;
  // Register byte offsets; each unit's control word sits one stride apart
  localparam logic [7:0] ACC_CTRL_BASE = 8'h00;
  localparam logic [7:0] ACC_CTRL_STRIDE = 8'h10;
  localparam logic [7:0] ACC_STAT_OFS = 8'h60;
  // Alias selector sits in address bits 3:2 (plain, clear, set, invert)
  typedef enum logic [1:0] {
    ACC_OP_WRITE = 2'b00,
    ACC_OP_CLR = 2'b01,
    ACC_OP_SET = 2'b10,
    ACC_OP_INV = 2'b11
  } acc_op_e;
  // Interrupt edge selection codes
  typedef enum logic [1:0] {
    ACC_EDGE_NONE = 2'b00,
    ACC_EDGE_RISE = 2'b01,
    ACC_EDGE_FALL = 2'b10,
    ACC_EDGE_BOTH = 2'b11
  } acc_edge_e;
  // Control register field positions
  localparam int ACC_ON_BIT = 15;
  localparam int ACC_OE_BIT = 14;
  localparam int ACC_INV_BIT = 13;
  localparam int ACC_RES_BIT = 8;
  localparam int ACC_EDGE_LO = 6;
  localparam int ACC_POS_BIT = 4;
  localparam int ACC_NEG_LO = 0;
  // Status register field positions
  localparam int ACC_STOP_IN_IDLE_BIT = 13;
  localparam int ACC_STAT_RES_LO = 0;
  // Reset values and writable masks
  localparam logic [15:0] ACC_CTRL_RST = 16'h00c3;
  localparam logic [15:0] ACC_CTRL_WMASK = 16'he0d3;
  localparam logic ACC_STOP_IN_IDLE_RST = 1'b0;
endpackage

// ===== common/acc_unit_if.sv
// Connection between the register core and one comparator unit
interface acc_unit_if;
  logic enable;
  logic invert;
  logic [1:0] edge_sel;
  logic raw;
  logic level;
  logic edge_evt;
  modport ctl (
    output enable, invert, edge_sel, raw,
    input level, edge_evt
  );
  modport unit (
    input enable, invert, edge_sel, raw,
    output level, edge_evt
  );
endinterface

// ===== core/acc_top.sv
// Register core of the analog comparator control block
//
// Behaviour
// [RULE1] Setting the enable bit turns the unit on, other fields kept.
// [RULE2] Clearing the enable bit stops the unit, other fields kept.
// [RULE3] Drive enable bit set puts the result on the unit's pin.
// [RULE4] Invert bit set inverts the result before any use.
// [RULE5] Inversion also feeds the edge detector, so edges swap.
// [RULE6] Read-only result bit shows the current level; writes ignored.
// [RULE7] Edge select 00 gives no event, 01 gives rising events.
// [RULE8] Edge select 10 gives falling events, 11 gives both.
// [RULE9] Positive select 1 picks ladder reference, 0 picks pin A.
// [RULE10] Negative select picks pin B, C, D or absolute reference.
// [RULE11] Unimplemented bits read zero and ignore writes.
// [RULE12] Stop-in-idle bit set disables all units during idle.
// [RULE13] Status low bits show unit 3, 2, 1 levels high to low.
// [RULE14] Software avoids register access right after clearing enable.
// [RULE15] Three independent units, own control words, shared status.
// [RULE16] Clear, set and invert aliases at plus 4, 8 and 12.
// [RULE17] Comparator outputs are synchronised before any use.
//
// Our own choices: the register offsets and the address-and-strobe port.
module acc_top
  import acc_pkg::*;
#(
  parameter int N_UNITS = ACC_UNITS
) (
  input wire logic clk, // Bus clock, 10 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [ACC_AW-1:0] addr, // Byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic idle_mode, // Device idle state
  input wire logic [N_UNITS-1:0] comparator_raw, // Analog outputs
  output logic [N_UNITS-1:0] unit_power_on, // Analog enable
  output logic [N_UNITS-1:0] positive_input_select, // 1 = ladder
  output logic [2*N_UNITS-1:0] negative_input_select, // Mux code
  output logic [N_UNITS-1:0] result_output_pin, // Pin level
  output logic [N_UNITS-1:0] result_output_pin_oe, // Pin drive
  output logic [N_UNITS-1:0] irq_event // Edge event pulse
);
  // Status layout has room for exactly three units
  if (N_UNITS != ACC_UNITS) begin : g_bad_units
    $error("acc_top: N_UNITS must be 3");
  end

  logic [15:0] ctrl_reg [N_UNITS];
  logic stop_in_idle_reg;
  logic [31:0] rdata_reg;
  logic [N_UNITS-1:0] on_reg;
  logic [N_UNITS-1:0] level;
  logic [N_UNITS-1:0] evt;
  logic word_ok;
  logic [3:0] reg_idx;
  acc_op_e op;
  logic stat_hit;
  logic stop_in_idle_next;
  logic [15:0] stat_word;

  // Address decode shared by reads and writes
  assign word_ok = (addr[1:0] == 2'b00);
  assign reg_idx = addr[7:4];
  assign op = acc_op_e'(addr[3:2]);
  assign stat_hit = word_ok &&
    ((addr & ~8'h0c) == ACC_STAT_OFS);

  // Plain write or alias; only bits written as one change on aliases
  function automatic logic [15:0] acc_apply(
    input logic [15:0] old,
    input logic [15:0] w,
    input acc_op_e o,
    input logic [15:0] mask
  );
    logic [15:0] res;
    res = old;
    case (o)
      ACC_OP_WRITE: res = w;
      ACC_OP_CLR: res = old & ~w; // [RULE16]
      ACC_OP_SET: res = old | w; // [RULE16]
      ACC_OP_INV: res = old ^ w; // [RULE16]
      default: res = old;
    endcase
    return res & mask; // [RULE11]
  endfunction

  // Per-unit control word, unit logic and pin mapping
  for (genvar i = 0; i < N_UNITS; i++) begin : g_unit
    acc_unit_if uif ();
    logic sel;

    assign sel = word_ok && (reg_idx == 4'(i)) &&
      (addr[7:4] == 4'((ACC_CTRL_BASE + 8'(i) * ACC_CTRL_STRIDE) >> 4));

    // Control word; enable changes alone leave other fields alone
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        ctrl_reg[i] <= ACC_CTRL_RST;
      end else if (wr_en && sel) begin
        ctrl_reg[i] <= acc_apply(ctrl_reg[i], wdata[15:0], op,
          ACC_CTRL_WMASK); // [RULE1] [RULE2] [RULE6] [RULE15]
      end
    end

    // Run enable: own bit, gated by the shared idle stop
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        on_reg[i] <= 1'b0;
      end else begin
        on_reg[i] <= ctrl_reg[i][ACC_ON_BIT] &
          ~(stop_in_idle_reg & idle_mode); // [RULE12]
      end
    end

    assign uif.enable = on_reg[i];
    assign uif.invert = ctrl_reg[i][ACC_INV_BIT];
    assign uif.edge_sel = ctrl_reg[i][ACC_EDGE_LO +: 2];
    assign uif.raw = comparator_raw[i];
    assign level[i] = uif.level;
    assign evt[i] = uif.edge_evt;

    acc_unit u_unit (
      .clk (clk),
      .rst_b (rst_b),
      .u (uif.unit)
    );

    // Input routing fields go straight to the analog muxes
    assign positive_input_select[i] =
      ctrl_reg[i][ACC_POS_BIT]; // [RULE9]
    assign negative_input_select[2*i +: 2] =
      ctrl_reg[i][ACC_NEG_LO +: 2]; // [RULE10]
    assign result_output_pin_oe[i] =
      ctrl_reg[i][ACC_OE_BIT]; // [RULE3]
  end

  // Pin level and events come from the unit flops
  assign result_output_pin = level; // [RULE3]
  assign irq_event = evt;
  assign unit_power_on = on_reg;

  // Shared stop-in-idle bit; aliases work here too
  always_comb begin
    stop_in_idle_next = acc_apply({2'b00, stop_in_idle_reg, 13'h0000}, wdata[15:0],
      op, 16'h2000) != 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_in_idle_reg <= ACC_STOP_IN_IDLE_RST;
    end else if (wr_en && stat_hit) begin
      stop_in_idle_reg <= stop_in_idle_next; // [RULE12]
    end
  end

  // Status word: idle stop plus the three result levels
  always_comb begin
    stat_word = 16'h0000;
    stat_word[ACC_STOP_IN_IDLE_BIT] = stop_in_idle_reg;
    stat_word[ACC_STAT_RES_LO +: ACC_UNITS] = level; // [RULE13]
  end

  // Read data register; aliases and holes read as zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en && word_ok && op == ACC_OP_WRITE) begin
      rdata_reg <= 32'h0000_0000; // [RULE11]
      if (reg_idx < 4'(N_UNITS)) begin
        rdata_reg[15:0] <= ctrl_reg[reg_idx[1:0]] |
          (16'(level[reg_idx[1:0]]) << ACC_RES_BIT); // [RULE6]
      end else if (stat_hit) begin
        rdata_reg[15:0] <= stat_word; // [RULE13]
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;

  // Checks on unit 0 stand for all units, which share one structure
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  localparam logic [7:0] A_U0 = 8'h00;
  localparam logic [7:0] A_U0_CLR = 8'h04;
  localparam logic [7:0] A_U0_SET = 8'h08;
  localparam logic [7:0] A_U0_INV = 8'h0c;

  AST_SET_ON_KEEPS: assert property ( // [RULE1]
    wr_en && addr == A_U0_SET && wdata[15:0] == 16'h8000
    |=> ctrl_reg[0][15] &&
    ctrl_reg[0][14:0] == $past(ctrl_reg[0][14:0])
  ) else $error("set of enable disturbed other fields");

  AST_CLR_ON_STOPS: assert property ( // [RULE2]
    wr_en && addr == A_U0_CLR && wdata[15:0] == 16'h8000
    |=> ctrl_reg[0][14:0] == $past(ctrl_reg[0][14:0])
    ##1 !unit_power_on[0] ##1 !result_output_pin[0]
  ) else $error("clear of enable did not stop unit");

  AST_OE_READBACK: assert property ( // [RULE3]
    rd_en && addr == A_U0
    |=> rdata[14] == result_output_pin_oe[0]
  ) else $error("drive enable readback differs from pin");

  AST_LEVEL_POLARITY: assert property ( // [RULE4]
    (unit_power_on[0] && $stable(comparator_raw[0]) &&
    $stable(ctrl_reg[0][13]))[*4]
    |-> result_output_pin[0] == (comparator_raw[0] ^ ctrl_reg[0][13])
  ) else $error("result level not raw input with polarity");

  AST_RISE_EVENT: assert property ( // [RULE7] [RULE5]
    irq_event[0] && $past(ctrl_reg[0][7:6]) == 2'b01
    |-> $past(result_output_pin[0], 1) &&
    !$past(result_output_pin[0], 2)
  ) else $error("rising event without rising level");

  AST_FALL_EVENT: assert property ( // [RULE8]
    irq_event[0] && $past(ctrl_reg[0][7:6]) == 2'b10
    |-> !$past(result_output_pin[0], 1) &&
    $past(result_output_pin[0], 2)
  ) else $error("falling event without falling level");

  AST_NO_EVENT_OFF: assert property ( // [RULE7]
    irq_event[0] |-> $past(ctrl_reg[0][7:6]) != 2'b00
  ) else $error("event while edge select is off");

  AST_RESULT_READ: assert property ( // [RULE6]
    rd_en && addr == A_U0
    |=> rdata[8] == $past(result_output_pin[0])
  ) else $error("result bit does not show level");

  AST_POS_SEL: assert property ( // [RULE9]
    wr_en && addr == A_U0
    |=> positive_input_select[0] == $past(wdata[4])
  ) else $error("positive select not taken");

  AST_NEG_SEL: assert property ( // [RULE10]
    wr_en && addr == A_U0
    |=> negative_input_select[1:0] == $past(wdata[1:0])
  ) else $error("negative select not taken");

  AST_HOLES_ZERO: assert property ( // [RULE11]
    rd_en && addr == A_U0
    |=> rdata[31:16] == 16'h0000 && rdata[12:9] == 4'h0 &&
    rdata[5] == 1'b0 && rdata[3:2] == 2'b00
  ) else $error("unimplemented bits not zero");

  AST_IDLE_STOP: assert property ( // [RULE12]
    stop_in_idle_reg && idle_mode |=> unit_power_on == '0
  ) else $error("unit running in idle with stop set");

  AST_STATUS_LEVELS: assert property ( // [RULE13]
    rd_en && addr == ACC_STAT_OFS
    |=> rdata[2:0] == $past(result_output_pin)
  ) else $error("status levels wrong");

  AST_INV_ALIAS: assert property ( // [RULE16]
    wr_en && addr == A_U0_INV
    |=> ctrl_reg[0] == ($past(ctrl_reg[0] ^ wdata[15:0]) &
    ACC_CTRL_WMASK)
  ) else $error("invert alias wrong");

  // Stopped units keep pin and events quiet, whatever the polarity
  AST_OFF_LEVEL_ZERO: assert property ( // [RULE2]
    !unit_power_on[0] |=> !result_output_pin[0]
  ) else $error("stopped unit shows a high level");

  AST_OFF_NO_EVENT: assert property ( // [RULE2]
    !unit_power_on[0] |=> !irq_event[0]
  ) else $error("stopped unit raised an event");

  AST_ON_POWER: assert property ( // [RULE1]
    ctrl_reg[0][ACC_ON_BIT] && !(stop_in_idle_reg && idle_mode)
    |=> unit_power_on[0]
  ) else $error("enabled unit not running");

  AST_OFF_POWER: assert property ( // [RULE2]
    !ctrl_reg[0][ACC_ON_BIT] |=> !unit_power_on[0]
  ) else $error("cleared enable left unit running");

  AST_IDLE_RUN: assert property ( // [RULE12]
    ctrl_reg[0][ACC_ON_BIT] && !stop_in_idle_reg && idle_mode
    |=> unit_power_on[0]
  ) else $error("unit stopped in idle without stop bit");

  AST_STOP_IN_IDLE_READ: assert property ( // [RULE12]
    rd_en && addr == ACC_STAT_OFS
    |=> rdata[ACC_STOP_IN_IDLE_BIT] == $past(stop_in_idle_reg)
  ) else $error("stop-in-idle readback wrong");

  AST_ALIAS_READ_ZERO: assert property ( // [RULE16]
    rd_en && addr == A_U0_CLR
    |=> rdata == 32'h0000_0000
  ) else $error("alias address read not zero");

  // Scenarios worth seeing at least once

  COV_EVENT: cover property (irq_event[0] ##1 !irq_event[0]);
  COV_IDLE: cover property (
    ctrl_reg[0][15] && stop_in_idle_reg && idle_mode ##1 !unit_power_on[0]);
  COV_STATUS: cover property (
    rd_en && addr == ACC_STAT_OFS ##1 rdata[0]);
  COV_FALL_EVENT: cover property (
    irq_event[0] && ctrl_reg[0][7:6] == 2'b10);
  COV_INV_EVENT: cover property (
    irq_event[0] && ctrl_reg[0][ACC_INV_BIT]);
endmodule

// ===== core/acc_unit.sv
// One comparator unit: synchroniser, inversion and edge detector
module acc_unit
  import acc_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst_b, // Synchronous reset, active low
  acc_unit_if.unit u // Control and result link
);
  logic [ACC_SYNC_STAGES-1:0] sync_reg;
  logic level_reg;
  logic prev_reg;
  logic live_reg;
  logic live_prev_reg;
  logic edge_reg;
  logic rise;
  logic fall;
  logic hit;

  // Two flops; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[0], u.raw}; // [RULE17]
    end
  end

  // Polarity applied once, so pin, readback and edges all agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_reg <= 1'b0;
    end else if (!u.enable) begin
      level_reg <= 1'b0; // [RULE2]
    end else begin
      level_reg <= sync_reg[1] ^ u.invert; // [RULE4] [RULE5]
    end
  end

  // History of level and of enable, so a turn-on is not seen as an edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
      live_reg <= 1'b0;
      live_prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_reg;
      live_reg <= u.enable;
      live_prev_reg <= live_reg;
    end
  end

  // Edge select decode
  always_comb begin
    rise = level_reg & ~prev_reg;
    fall = ~level_reg & prev_reg;
    case (acc_edge_e'(u.edge_sel))
      ACC_EDGE_NONE: hit = 1'b0; // [RULE7]
      ACC_EDGE_RISE: hit = rise; // [RULE7]
      ACC_EDGE_FALL: hit = fall; // [RULE8]
      ACC_EDGE_BOTH: hit = rise | fall; // [RULE8]
      default: hit = 1'b0;
    endcase
  end

  // One-cycle event pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= hit & live_reg & live_prev_reg & u.enable;
    end
  end

  assign u.level = level_reg;
  assign u.edge_evt = edge_reg;
endmodule

// ===== testbench/test_acc_top.sv
// Self-checking bench for the comparator control register core
module test_acc_top import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ACC_AW-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic idle_mode = 1'b0;
  logic [2:0] comparator_raw = 3'h0;
  logic [2:0] unit_power_on;
  logic [2:0] positive_input_select;
  logic [5:0] negative_input_select;
  logic [2:0] result_output_pin;
  logic [2:0] result_output_pin_oe;
  logic [2:0] irq_event;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  acc_top #(.N_UNITS(3)) dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .idle_mode(idle_mode),
    .comparator_raw(comparator_raw),
    .unit_power_on(unit_power_on),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .result_output_pin(result_output_pin),
    .result_output_pin_oe(result_output_pin_oe),
    .irq_event(irq_event)
  );

  // 10 MHz bus clock
  always #50 clk = ~clk;

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; the slave never stalls
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, d};
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  // Count event pulses over eight cycles after a raw change
  task count_evt(input int idx, output int n);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (irq_event[idx] === 1'b1)
        n++;
    end
  endtask

  task t_reset;
    rdchk(8'h00, 32'h0000_00c3, "ctrl unit1");
    rdchk(8'h10, 32'h0000_00c3, "ctrl unit2");
    rdchk(8'h20, 32'h0000_00c3, "ctrl unit3");
    rdchk(8'h60, 32'h0000_0000, "status");
    chk("neg sel", 32'h3f, {26'h0, negative_input_select});
    $display("Test reset values done");
  endtask

  // Unimplemented bits, read-only level bit, aliases, enable keeps fields
  task t_fields;
    wr(8'h00, 16'h7f2c);
    rdchk(8'h00, 32'h0000_6000, "masked ctrl");
    chk("pin drive", 32'h1, {31'h0, result_output_pin_oe[0]});
    wr(8'h08, 16'h8000);
    wr(8'h08, 16'h0100);
    repeat (4) @(posedge clk);
    rdchk(8'h00, 32'h0000_e100, "on inverted");
    chk("pin inverted", 32'h1, {31'h0, result_output_pin[0]});
    wr(8'h04, 16'h2000);
    repeat (4) @(posedge clk);
    rdchk(8'h00, 32'h0000_c000, "invert cleared");
    chk("pin plain", 32'h0, {31'h0, result_output_pin[0]});
    wr(8'h0c, 16'h8000);
    repeat (3) @(posedge clk);
    rdchk(8'h00, 32'h0000_4000, "off fields kept");
    chk("power off", 32'h0, {31'h0, unit_power_on[0]});
    wr(8'h08, 16'h8000);
    wr(8'h04, 16'h8000);
    repeat (3) @(posedge clk);
    rdchk(8'h00, 32'h0000_4000, "clear alias off");
    chk("clear power off", 32'h0, {31'h0, unit_power_on[0]});
    wr(8'h00, 16'h0000);
    rdchk(8'h04, 32'h0, "alias read");
    rdchk(8'h40, 32'h0, "unmapped read");
    $display("Test fields and aliases done");
  endtask

  // Every edge code, with and without inversion, on every unit
  task t_edges;
    int n;
    int j;
    logic inv;
    logic [1:0] e;
    logic [7:0] a;
    for (j = 0; j < 3; j++) begin
      a = 8'(16 * j);
      for (int k = 0; k < 8; k++) begin
        inv = k[2];
        e = k[1:0];
        wr(a, 16'h0000);
        wr(a, {1'b1, 1'b0, inv, 5'h00, e, 6'h00});
        repeat (6) @(posedge clk);
        comparator_raw[j] <= 1'b1;
        count_evt(j, n);
        chk("rise events", 32'(inv ? e[1] : e[0]), 32'(n));
        chk("level", {31'h0, ~inv}, 32'(result_output_pin[j]));
        @(posedge clk);
        comparator_raw[j] <= 1'b0;
        count_evt(j, n);
        chk("fall events", 32'(inv ? e[0] : e[1]), 32'(n));
      end
      wr(a, 16'h0000);
    end
    $display("Test edge selection done");
  endtask

  // Every input selection code on unit 3
  task t_selects;
    for (int k = 0; k < 8; k++) begin
      wr(8'h20, {11'h000, k[2], 2'b00, k[1:0]});
      repeat (2) @(posedge clk);
      #1;
      chk("pos sel", 32'(k[2]), {31'h0, positive_input_select[2]});
      chk("neg sel", 32'(k[1:0]), {30'h0, negative_input_select[5:4]});
    end
    $display("Test input selection done");
  endtask

  // Status levels, idle stop and the status clear alias
  task t_status;
    wr(8'h00, 16'h8000);
    wr(8'h10, 16'h8000);
    wr(8'h20, 16'h8000);
    @(posedge clk);
    comparator_raw <= 3'b101;
    repeat (5) @(posedge clk);
    rdchk(8'h60, 32'h0000_0005, "status levels");
    wr(8'h60, 16'hffff);
    rdchk(8'h60, 32'h0000_2005, "status masked");
    @(posedge clk);
    idle_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("idle stopped", 32'h0, {29'h0, unit_power_on});
    wr(8'h64, 16'h2000);
    repeat (3) @(posedge clk);
    #1;
    chk("idle running", 32'h7, {29'h0, unit_power_on});
    @(posedge clk);
    idle_mode <= 1'b0;
    $display("Test status and idle done");
  endtask

  // Main sequence: reset held for ten cycles, then the tests
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_edges();
    t_selects();
    t_status();
    complete_run();
  end
endmodule
